// >>> mcari_pkg.sv
// Overview of operation
// - Wait-state mode: host holds channel address stable while strobes are low.
// - Wait-state host stretches its read until ready or completion shows, or until twice the conversion time passes.
// - Pipelined mode: ready carries no status and is not used.
// - Pipelined mode: host leaves at least 2.5 us between reads.
// - Host reaches converter like a ROM: chip select, read, address only.
`default_nettype none

package mcari_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] MCARI_ADDR_CTRL     = 8'h00;
    localparam logic [7:0] MCARI_ADDR_CMD      = 8'h04;
    localparam logic [7:0] MCARI_ADDR_STATUS   = 8'h08;
    localparam logic [7:0] MCARI_ADDR_DATA     = 8'h0C;
    localparam logic [7:0] MCARI_ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] MCARI_ADDR_IRQ_MASK = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         MCARI_CTRL_PIPE_BIT  = 0;
    localparam int         MCARI_CTRL_FOUR_BIT  = 1;
    localparam logic [1:0] MCARI_CTRL_RESET     = 2'h0;
    localparam int         MCARI_CMD_START_BIT  = 8;
    localparam int         MCARI_IRQ_READ_DONE  = 0;
    localparam int         MCARI_IRQ_DEV_DONE   = 1;
    localparam int         MCARI_IRQ_TIMEOUT    = 2;
    localparam logic [2:0] MCARI_IRQ_RESET      = 3'h0;
    localparam logic [7:0] MCARI_BIPOLAR_MID    = 8'h80;

    // ************************************************************
    // Timing, in ns and in 200 MHz cycles
    // ************************************************************
    localparam int         MCARI_CLK_MHZ    = 200;
    localparam int         MCARI_CONV_NS    = 2000;
    localparam int         MCARI_GAP_NS     = 2500;
    localparam int         MCARI_STROBE_NS  = 100;
    localparam int         MCARI_CONV_CYC   = MCARI_CONV_NS * MCARI_CLK_MHZ / 1000;
    localparam int         MCARI_GAP_CYC    =
        (MCARI_GAP_NS * MCARI_CLK_MHZ + 999) / 1000;
    localparam int         MCARI_STROBE_CYC =
        (MCARI_STROBE_NS * MCARI_CLK_MHZ + 999) / 1000;
    localparam logic [9:0] MCARI_TIMEOUT_LIM = 10'(2 * MCARI_CONV_CYC);
    localparam logic [9:0] MCARI_GAP_LIM     = 10'(MCARI_GAP_CYC);
    localparam logic [9:0] MCARI_STROBE_LIM  = 10'(MCARI_STROBE_CYC);

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        MCARI_IDLE   = 3'b000,
        MCARI_SETUP  = 3'b001,
        MCARI_WAIT   = 3'b010,
        MCARI_STROBE = 3'b011,
        MCARI_HOLD   = 3'b100,
        MCARI_GAP    = 3'b101
    } mcari_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic [2:0] chan;
    } mcari_pins_t;

    // Bipolar code to signed steps of 31.25 mV
    function automatic logic [15:0] mcari_bipolar(input logic [7:0] code);
        mcari_bipolar = 16'({8'h00, MCARI_BIPOLAR_MID} - {8'h00, code});
    endfunction

endpackage : mcari_pkg

`default_nettype wire

// >>> mcari_host.sv
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module mcari_host (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic                     irq,
    output mcari_pkg::mcari_pins_t   adc_pins,
    input  wire logic [7:0]          result_bus,
    input  wire logic                adc_ready,
    input  wire logic                adc_done_n
);
    import mcari_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    mcari_state_t state_reg;
    logic [9:0]   cnt_reg;
    logic [1:0]   ctrl_reg;
    logic [2:0]   chan_reg;
    logic [7:0]   result_reg;
    logic [2:0]   res_chan_reg;
    logic [2:0]   irq_stat_reg;
    logic [2:0]   irq_mask_reg;
    logic         done_n_prev_reg;
    logic         wr_pend_reg;
    logic         rd_pend_reg;
    logic [7:0]   addr_reg;
    logic [31:0]  hrdata_reg;
    logic         addr_phase;
    logic         wr_cmd;
    logic         start;
    logic         answer;
    logic [2:0]   irq_set;
    logic [2:0]   irq_clr;
    logic [31:0]  rd_mux;

    // ************************************************************
    // Bus slave
    // ************************************************************

    // Address phase seen
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_cmd     = wr_pend_reg && (addr_reg == MCARI_ADDR_CMD);
    assign start      = wr_cmd && hwdata[MCARI_CMD_START_BIT]
                        && (state_reg == MCARI_IDLE);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            if (hready || rd_pend_reg) begin
                wr_pend_reg <= addr_phase && hwrite;
                rd_pend_reg <= addr_phase && !hwrite;
            end
            if (addr_phase) begin
                addr_reg <= {haddr[7:2], 2'b00};
            end
        end
    end

    // Read mux, unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            MCARI_ADDR_CTRL:     rd_mux = {30'h0, ctrl_reg};
            MCARI_ADDR_CMD:      rd_mux = {29'h0, chan_reg};
            MCARI_ADDR_STATUS:   rd_mux = {25'h0, chan_reg, adc_done_n,
                                           state_reg};
            MCARI_ADDR_DATA:     rd_mux = {mcari_bipolar(result_reg),
                                           5'h00, res_chan_reg,
                                           result_reg};
            MCARI_ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
            MCARI_ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data, one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = !rd_pend_reg;
    assign hresp     = 1'b0;

    // Control and mask registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg     <= MCARI_CTRL_RESET;
            irq_mask_reg <= MCARI_IRQ_RESET;
            chan_reg     <= 3'h0;
        end else begin
            if (wr_pend_reg && addr_reg == MCARI_ADDR_CTRL) begin
                ctrl_reg <= hwdata[1:0];
            end
            if (wr_pend_reg && addr_reg == MCARI_ADDR_IRQ_MASK) begin
                irq_mask_reg <= hwdata[2:0];
            end
            if (start) begin
                chan_reg <= ctrl_reg[MCARI_CTRL_FOUR_BIT] ?
                            {1'b0, hwdata[1:0]} : hwdata[2:0];
            end
        end
    end

    // ************************************************************
    // Converter sequencer
    // ************************************************************

    // Wait-state answer: ready released or completion low
    assign answer = adc_ready || !adc_done_n;

    // Sequence state and cycle counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= MCARI_IDLE;
            cnt_reg   <= 10'h000;
        end else begin
            cnt_reg <= cnt_reg + 10'h001;
            case (state_reg)
                MCARI_IDLE: begin
                    if (start) begin
                        state_reg <= MCARI_SETUP;
                    end
                end
                MCARI_SETUP: begin
                    cnt_reg   <= 10'h000;
                    state_reg <= ctrl_reg[MCARI_CTRL_PIPE_BIT] ?
                                 MCARI_STROBE : MCARI_WAIT;
                end
                MCARI_WAIT: begin
                    if (answer || cnt_reg >= MCARI_TIMEOUT_LIM) begin
                        state_reg <= MCARI_HOLD;
                    end
                end
                MCARI_STROBE: begin
                    if (cnt_reg >= MCARI_STROBE_LIM - 10'h001) begin
                        cnt_reg   <= 10'h000;
                        state_reg <= MCARI_HOLD;
                    end
                end
                MCARI_HOLD: begin
                    state_reg <= ctrl_reg[MCARI_CTRL_PIPE_BIT] ?
                                 MCARI_GAP : MCARI_IDLE;
                end
                MCARI_GAP: begin
                    if (cnt_reg >= MCARI_GAP_LIM - 10'h001) begin
                        state_reg <= MCARI_IDLE;
                    end
                end
                default: begin
                    state_reg <= MCARI_IDLE;
                end
            endcase
        end
    end

    // Result capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_reg   <= 8'h00;
            res_chan_reg <= 3'h0;
        end else if ((state_reg == MCARI_WAIT && answer) ||
                     (state_reg == MCARI_STROBE &&
                      cnt_reg >= MCARI_STROBE_LIM - 10'h001)) begin
            result_reg   <= result_bus;
            res_chan_reg <= chan_reg;
        end
    end

    // Pins: address held from setup through hold, ROM-style read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_pins <= '{cs_n: 1'b1, rd_n: 1'b1, chan: 3'h0};
        end else begin
            adc_pins.cs_n <= !(state_reg == MCARI_SETUP ||
                               (state_reg == MCARI_WAIT && !answer &&
                                cnt_reg < MCARI_TIMEOUT_LIM) ||
                               (state_reg == MCARI_STROBE &&
                                cnt_reg < MCARI_STROBE_LIM - 10'h001));
            adc_pins.rd_n <= !(state_reg == MCARI_SETUP ||
                               (state_reg == MCARI_WAIT && !answer &&
                                cnt_reg < MCARI_TIMEOUT_LIM) ||
                               (state_reg == MCARI_STROBE &&
                                cnt_reg < MCARI_STROBE_LIM - 10'h001));
            if (start) begin
                adc_pins.chan <= ctrl_reg[MCARI_CTRL_FOUR_BIT] ?
                                 {1'b0, hwdata[1:0]} : hwdata[2:0];
            end
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************

    // Completion fall detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_n_prev_reg <= 1'b1;
        end else begin
            done_n_prev_reg <= adc_done_n;
        end
    end

    // Events: ready is ignored in pipelined mode
    assign irq_set[MCARI_IRQ_READ_DONE] = state_reg == MCARI_HOLD;
    assign irq_set[MCARI_IRQ_DEV_DONE]  = done_n_prev_reg && !adc_done_n;
    assign irq_set[MCARI_IRQ_TIMEOUT]   = state_reg == MCARI_WAIT && !answer
                                          && cnt_reg >= MCARI_TIMEOUT_LIM;
    assign irq_clr = (wr_pend_reg && addr_reg == MCARI_ADDR_IRQ_STAT) ?
                     hwdata[2:0] : 3'h0;

    // Sticky status, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= MCARI_IRQ_RESET;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // mcari_host

`default_nettype wire

// >>> mcari_host_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mcari_host_assertions (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hsel,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic                   irq,
    input wire mcari_pkg::mcari_pins_t adc_pins,
    input wire logic                   adc_ready
);
    import mcari_pkg::*;
    logic [9:0] low_cnt;
    logic       req;
    logic [9:0] high_cnt;
    logic       last_short;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles the strobes have stayed low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            low_cnt <= 10'h000;
        else if (adc_pins.cs_n)
            low_cnt <= 10'h000;
        else
            low_cnt <= low_cnt + 10'h001;
    end
    // Cycles since the strobes rose, and whether that read was short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_cnt   <= 10'h000;
            last_short <= 1'b0;
        end else if (!adc_pins.cs_n) begin
            high_cnt   <= 10'h000;
            last_short <= low_cnt < 10'd20;
        end else if (high_cnt != 10'h3FF) begin
            high_cnt <= high_cnt + 10'h001;
        end
    end
    // Bus request taken
    assign req = hsel && hready && htrans[1];
    sequence s_read_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    a_strobes_paired: assert property (adc_pins.cs_n == adc_pins.rd_n)
        else $error("strobes differ");
    a_chan_steady: assert property (
        !adc_pins.cs_n |-> $stable(adc_pins.chan))
        else $error("channel moved under strobes");
    a_read_wait: assert property (req && !hwrite |=> s_read_answer)
        else $error("read answer timing wrong");
    a_write_no_wait: assert property (req && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property (
        hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("hrdata changed without read");
    a_ready_answer: assert property (
        !adc_pins.cs_n && adc_ready |=> adc_pins.cs_n)
        else $error("strobes held after ready");
    a_read_gap: assert property (
        $fell(adc_pins.cs_n) && last_short |-> high_cnt >= 10'd500)
        else $error("pipelined reads too close");
    a_strobe_length: assert property ($rose(adc_pins.cs_n) |->
        low_cnt == 10'd20 || $past(adc_ready) || low_cnt > 10'd799)
        else $error("strobe released at wrong time");
    a_reset_quiet: assert property (
        $rose(hresetn) |-> adc_pins.cs_n && !irq)
        else $error("activity right after reset");
endmodule // mcari_host_assertions
`default_nettype wire

// >>> mcari_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcari_adc_model #(
    parameter int CONV = 400
) (
    input wire logic       clk,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic [2:0] chan,
    input wire logic       pipe,
    output logic [7:0]     data,
    output logic           rdy_oe_n,
    output logic           done_n = 1'b1
);
    logic       strobe;
    logic       waiting;
    logic       drive;
    logic       strobe_q = 1'b0;
    logic       busy = 1'b0;
    logic [2:0] conv_ch = 3'h0;
    logic [7:0] res = 8'h00;
    logic [7:0] last = 8'h00;
    int         cnt = 0;
    // Read strobes, ready pin and result bus
    assign strobe   = !cs_n && !rd_n;
    assign waiting  = busy || !strobe_q;
    assign rdy_oe_n = cs_n || !waiting;
    assign drive    = strobe && (pipe || !waiting);
    assign data     = drive ? res : ~last; // Floating bus shows inverse
    // Start, finish and strobe rise
    always @(posedge clk) begin
        strobe_q <= strobe;
        if (drive)
            last <= res;
        if (strobe && !strobe_q) begin
            busy    <= 1'b1;
            cnt     <= 0;
            conv_ch <= chan;
        end else if (busy && cnt == CONV - 1) begin
            busy   <= 1'b0;
            res    <= 8'h13 + {conv_ch, 5'h00};
            done_n <= 1'b0;
        end else if (busy)
            cnt <= cnt + 1;
        if (!strobe && strobe_q) begin
            done_n <= 1'b1;
            conv_ch <= chan;
        end
    end
endmodule // mcari_adc_model
`default_nettype wire

// >>> test_mcari_host.sv
`timescale 1ns/100ps
`default_nettype none
module test_mcari_host;
    import mcari_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        pipe_mode = 1'b0;
    logic        mute = 1'b0;
    logic        dev_done_n;
    logic [31:0] hrdata, rd, st;
    logic        hreadyout, hresp, irq, adc_ready, adc_done_n, rdy_oe_n;
    logic [7:0]  result_bus;
    mcari_pins_t adc_pins;
    int          err_count = 0;
    int          tests_run = 0;
    // Clock and the pulled-up ready line
    always #2.5 hclk = ~hclk;
    assign adc_ready  = (pipe_mode || mute) ? 1'b0 : rdy_oe_n;
    // Mute hides the converter's answer to force a timeout
    assign adc_done_n = dev_done_n || mute;
    mcari_host mcari_host_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .adc_pins(adc_pins),
        .result_bus(result_bus), .adc_ready(adc_ready),
        .adc_done_n(adc_done_n));
    mcari_adc_model mcari_adc_model_i (
        .clk(hclk), .cs_n(adc_pins.cs_n), .rd_n(adc_pins.rd_n),
        .chan(adc_pins.chan), .pipe(pipe_mode), .data(result_bus),
        .rdy_oe_n(rdy_oe_n), .done_n(dev_done_n));
    // Expected code of a channel
    function automatic logic [7:0] code(input logic [2:0] c);
        return 8'h13 + {c, 5'h00};
    endfunction
    task automatic check(input string name, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s: expected %h seen %h", name, exp, got);
        end
    endtask
    // One AHB single transfer, called just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Start a read, wait for idle, fetch the result
    task automatic convert(input logic [2:0] c);
        int n;
        n = 0;
        xfer(MCARI_ADDR_CMD, 1'b1, {23'h0, 1'b1, 5'h0, c});
        do begin
            xfer(MCARI_ADDR_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[2:0] !== 3'h0 && n < 1000);
        st = rd;
        xfer(MCARI_ADDR_DATA, 1'b0, 32'h0);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(MCARI_ADDR_IRQ_MASK, 1'b0, 32'h0);
        check("mask", rd, 32'h0);
        xfer(8'h18, 1'b1, 32'hFFFFFFFF);
        xfer(8'h18, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        for (int c = 0; c < 8; c++) begin
            convert(3'(c));
            check("status", st & 32'h7F, {25'h0, 3'(c), 4'h8});
            check("data", rd & 32'hFFFF07FF, {16'(16'h0080 -
                {8'h00, code(3'(c))}), 5'h00, 3'(c), code(3'(c))});
        end
        xfer(MCARI_ADDR_CMD, 1'b1, 32'h0000_0101);
        convert(3'h6);
        check("refused", rd & 32'h7FF, {21'h0, 3'h1, code(3'h1)});
        mute <= 1'b1;
        convert(3'h4);
        mute <= 1'b0;
        check("timeout", rd & 32'h7FF, {21'h0, 3'h1, code(3'h1)});
        xfer(MCARI_ADDR_IRQ_STAT, 1'b0, 32'h0);
        check("irq_stat", rd, 32'h7);
        check("irq_off", {31'h0, irq}, 32'h0);
        xfer(MCARI_ADDR_IRQ_MASK, 1'b1, 32'h2);
        @(posedge hclk);
        check("irq_on", {31'h0, irq}, 32'h1);
        xfer(MCARI_ADDR_IRQ_STAT, 1'b1, 32'h3);
        @(posedge hclk);
        check("irq_clr", {31'h0, irq}, 32'h0);
        xfer(MCARI_ADDR_CTRL, 1'b1, 32'h2);
        convert(3'h7);
        check("four", rd & 32'h7FF, {21'h0, 3'h3, code(3'h3)});
        xfer(MCARI_ADDR_CTRL, 1'b1, 32'h1);
        pipe_mode <= 1'b1;
        convert(3'h2);
        check("pipe_old", rd & 32'h7FF, {21'h0, 3'h2, code(3'h3)});
        check("pipe_done", {31'h0, st[3]}, 32'h0);
        convert(3'h5);
        check("pipe_new", rd & 32'h7FF, {21'h0, 3'h5, code(3'h2)});
        test_done();
    end
    // Watchdog
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // test_mcari_host
bind mcari_host mcari_host_assertions mcari_host_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .adc_pins(adc_pins), .adc_ready(adc_ready));
`default_nettype wire
